// *** src/fpo_pkg.sv ***
// Package: register map, field layout and operation codes of the flash operand block
package fpo_pkg;
    // Register word offsets (byte addresses)
    localparam logic [5:0] OFS_CONTROL = 6'h00;
    localparam logic [5:0] OFS_KEY = 6'h04;
    localparam logic [5:0] OFS_TARGET = 6'h08;
    localparam logic [5:0] OFS_DATA0 = 6'h0C;
    localparam logic [5:0] OFS_DATA1 = 6'h10;
    localparam logic [5:0] OFS_DATA2 = 6'h14;
    localparam logic [5:0] OFS_DATA3 = 6'h18;
    localparam logic [5:0] OFS_SOURCE = 6'h1C;
    localparam logic [5:0] OFS_CONTROL2 = 6'h20;
    localparam logic [5:0] OFS_STATUS = 6'h24;
    // Control register field positions
    localparam int CTL_GO_BIT = 15;
    localparam int CTL_ARM_BIT = 14;
    localparam int CTL_ERR_BIT = 13;
    localparam int CTL_LVD_BIT = 12;
    localparam int CTL_PSWAP_BIT = 7;
    localparam int CTL_BSWAP_BIT = 6;
    localparam int CTL_OP_LSB = 0;
    // Control 2: swap lock field
    localparam int CTL2_LOCK_LSB = 6;
    // Address masks per granularity
    localparam logic [31:0] MASK_PAGE = 32'hFFFF_F000;
    localparam logic [31:0] MASK_ROW = 32'hFFFF_FE00;
    localparam logic [31:0] MASK_QUAD = 32'hFFFF_FFF0;
    localparam logic [31:0] MASK_WORD = 32'hFFFF_FFFC;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // Unlock key values (arbitrary)
    localparam logic [31:0] KEY_FIRST = 32'h1234_5678;
    localparam logic [31:0] KEY_SECOND = 32'h8765_4321;

    typedef enum logic [3:0]
    {
        OP_NONE = 4'h0,
        OP_WORD = 4'h1,
        OP_QUAD = 4'h2,
        OP_ROW = 4'h3,
        OP_PAGE = 4'h4
    } fpo_op_e;

    typedef enum logic [1:0]
    {
        UNLK_IDLE,
        UNLK_HALF,
        UNLK_OPEN
    } fpo_unlk_e;

    // Operands handed to the array sequencer
    typedef struct packed
    {
        logic [3:0] op;
        logic [31:0] address;
        logic addr_used;
        logic [127:0] data;
        logic [31:0] source;
    } fpo_cmd_s;
endpackage

// *** src/fpo_regs.sv ***
// Flash program operand, unlock and control registers behind an Avalon-MM slave
// Notes on behaviour
// R1: Key register is write-only; every read returns zero.
// R2: Key writes serve only the unlock sequence protecting program flash.
// R3: Page erase ignores target address bits 11:0.
// R4: Row program ignores target address bits 8:0.
// R5: Word program ignores target address bits 1:0.
// R6: Quad word program selects 128-bit aligned word, ignoring bits 3:0.
// R7: Other operations disregard the target address entirely.
// R8: Word program writes data register zero.
// R9: Quad program writes data 3,2,1,0; data zero least significant.
// R10: Row program fetches data from the source address register.
// R11: Address, data and source registers clear only on power-on reset.
// R12: Go, arm and error flags reset only on power-on reset.
// R13: Swap bits change only with arm low, unlocked and swap locks clear; boot swap also reloads from i_boot_seq_swap on any system reset.
// R14: Boot swap value comes from programmed boot panel sequence numbers.
// R15: Operation codes: 1 word, 2 quad, 3 row, 4 page, 0 none.
// R16: Go set only with arm high after unlock; software never clears it.
// R17: Unlock needs the key values written in order to the key register.
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module fpo_regs #(
    parameter logic [31:0] KEY_A = fpo_pkg::KEY_FIRST,
    parameter logic [31:0] KEY_B = fpo_pkg::KEY_SECOND
)
(
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_sys_rst_n,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [1:0] o_avs_response,
    input wire logic i_boot_seq_swap,
    input wire logic i_op_done,
    input wire logic i_op_fail,
    input wire logic i_low_voltage,
    output fpo_pkg::fpo_cmd_s o_cmd,
    output logic o_go,
    output logic o_write_arm,
    output logic o_program_bank_swap,
    output logic o_boot_bank_swap
);

    logic [31:0] target_r;
    logic [31:0] data_r [4];
    logic [31:0] source_r;
    logic [3:0] op_r;
    logic go_r;
    logic arm_r;
    logic err_r;
    logic lvd_r;
    logic pswap_r;
    logic bswap_r;
    logic [1:0] lock_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [1:0] resp_r;
    fpo_pkg::fpo_unlk_e unlk_r;
    logic wr_acc;
    logic rd_acc;
    logic unlocked;

    // Byte-lane merge used by the target, data and source words
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // One wait cycle per access keeps read data registered
    assign wr_acc = i_avs_write && !ack_r;
    assign rd_acc = i_avs_read && !ack_r;
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;
    assign o_avs_readdata = rdata_r;
    assign o_avs_response = resp_r;
    assign unlocked = (unlk_r == fpo_pkg::UNLK_OPEN);

    // Handshake: acknowledge lasts exactly one cycle
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= (i_avs_read || i_avs_write) && !ack_r;
        end
    end

    // Unlock tracker; a wrong key write or a control write breaks the sequence
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            unlk_r <= fpo_pkg::UNLK_IDLE;
        end
        else if (!i_sys_rst_n)
        begin
            unlk_r <= fpo_pkg::UNLK_IDLE;
        end
        else if (wr_acc)
        begin
            if (i_avs_address == fpo_pkg::OFS_KEY)
            begin
                if (unlk_r == fpo_pkg::UNLK_IDLE && i_avs_writedata == KEY_A) // R17 R2
                begin
                    unlk_r <= fpo_pkg::UNLK_HALF;
                end
                else if (unlk_r == fpo_pkg::UNLK_HALF && i_avs_writedata == KEY_B) // R17
                begin
                    unlk_r <= fpo_pkg::UNLK_OPEN;
                end
                else
                begin
                    unlk_r <= fpo_pkg::UNLK_IDLE;
                end
            end
            else if (i_avs_address == fpo_pkg::OFS_CONTROL && unlk_r == fpo_pkg::UNLK_HALF)
            begin
                unlk_r <= fpo_pkg::UNLK_IDLE;
            end
            else if (unlk_r == fpo_pkg::UNLK_OPEN && i_avs_address == fpo_pkg::OFS_CONTROL)
            begin
                // Unlock is consumed by the next control write
                unlk_r <= fpo_pkg::UNLK_IDLE;
            end
        end
    end

    // Operand registers: only the power-on reset clears them
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            target_r <= fpo_pkg::RST_WORD; // R11
            source_r <= fpo_pkg::RST_WORD; // R11
            for (int i = 0; i < 4; i++)
            begin
                data_r[i] <= fpo_pkg::RST_WORD; // R11
            end
        end
        else if (wr_acc)
        begin
            if (i_avs_address == fpo_pkg::OFS_TARGET)
            begin
                target_r <= merge(target_r, i_avs_writedata, i_avs_byteenable);
            end
            else if (i_avs_address == fpo_pkg::OFS_DATA0)
            begin
                data_r[0] <= merge(data_r[0], i_avs_writedata, i_avs_byteenable);
            end
            else if (i_avs_address == fpo_pkg::OFS_DATA1)
            begin
                data_r[1] <= merge(data_r[1], i_avs_writedata, i_avs_byteenable);
            end
            else if (i_avs_address == fpo_pkg::OFS_DATA2)
            begin
                data_r[2] <= merge(data_r[2], i_avs_writedata, i_avs_byteenable);
            end
            else if (i_avs_address == fpo_pkg::OFS_DATA3)
            begin
                data_r[3] <= merge(data_r[3], i_avs_writedata, i_avs_byteenable);
            end
            else if (i_avs_address == fpo_pkg::OFS_SOURCE)
            begin
                source_r <= merge(source_r, i_avs_writedata, i_avs_byteenable); // R10
            end
        end
    end

    // Control flags; power-on reset only, system reset does not touch them
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            go_r <= 1'b0; // R12
            arm_r <= 1'b0; // R12
            err_r <= 1'b0; // R12
            lvd_r <= 1'b0; // R12
            op_r <= 4'h0;
            pswap_r <= 1'b0;
            lock_r <= 2'h0;
        end
        else
        begin
            // Hardware completion clears go; a late software set still wins
            if (go_r && i_op_done)
            begin
                go_r <= 1'b0;
                if (op_r == fpo_pkg::OP_NONE)
                begin
                    err_r <= 1'b0;
                    lvd_r <= 1'b0;
                end
                else
                begin
                    err_r <= i_op_fail;
                    lvd_r <= i_low_voltage;
                end
            end
            if (wr_acc && i_avs_address == fpo_pkg::OFS_CONTROL2 && i_avs_byteenable[0])
            begin
                lock_r <= i_avs_writedata[fpo_pkg::CTL2_LOCK_LSB +: 2];
            end
            if (wr_acc && i_avs_address == fpo_pkg::OFS_CONTROL)
            begin
                if (i_avs_byteenable[1])
                begin
                    arm_r <= i_avs_writedata[fpo_pkg::CTL_ARM_BIT];
                    // Go only sets, never clears from software
                    if (i_avs_writedata[fpo_pkg::CTL_GO_BIT] && arm_r && unlocked) // R16
                    begin
                        go_r <= 1'b1;
                    end
                end
                if (i_avs_byteenable[0] && !arm_r)
                begin
                    op_r <= i_avs_writedata[fpo_pkg::CTL_OP_LSB +: 4];
                    if (unlocked && lock_r == 2'h0) // R13
                    begin
                        pswap_r <= i_avs_writedata[fpo_pkg::CTL_PSWAP_BIT];
                    end
                end
            end
        end
    end

    // Boot swap reloads from panel sequence numbers when unlocked edits are allowed
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            bswap_r <= 1'b0;
        end
        else if (wr_acc && i_avs_address == fpo_pkg::OFS_CONTROL && i_avs_byteenable[0] && !arm_r
                 && unlocked && lock_r == 2'h0) // R13
        begin
            bswap_r <= i_boot_seq_swap; // R14
        end
        else if (!i_sys_rst_n)
        begin
            bswap_r <= i_boot_seq_swap; // R14
        end
    end

    // Registered read path; unmapped addresses answer SLVERR
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rdata_r <= fpo_pkg::RST_WORD;
            resp_r <= 2'h0;
        end
        else if (rd_acc || wr_acc)
        begin
            rdata_r <= fpo_pkg::RST_WORD;
            resp_r <= 2'h0;
            if (i_avs_address == fpo_pkg::OFS_CONTROL)
            begin
                rdata_r <= {16'h0000, go_r, arm_r, err_r, lvd_r, 4'h0, pswap_r, bswap_r, 2'h0, op_r};
            end
            else if (i_avs_address == fpo_pkg::OFS_KEY)
            begin
                rdata_r <= fpo_pkg::RST_WORD; // R1
            end
            else if (i_avs_address == fpo_pkg::OFS_TARGET)
            begin
                rdata_r <= target_r;
            end
            else if (i_avs_address == fpo_pkg::OFS_DATA0)
            begin
                rdata_r <= data_r[0];
            end
            else if (i_avs_address == fpo_pkg::OFS_DATA1)
            begin
                rdata_r <= data_r[1];
            end
            else if (i_avs_address == fpo_pkg::OFS_DATA2)
            begin
                rdata_r <= data_r[2];
            end
            else if (i_avs_address == fpo_pkg::OFS_DATA3)
            begin
                rdata_r <= data_r[3];
            end
            else if (i_avs_address == fpo_pkg::OFS_SOURCE)
            begin
                rdata_r <= source_r;
            end
            else if (i_avs_address == fpo_pkg::OFS_CONTROL2)
            begin
                rdata_r <= {24'h000000, lock_r, 6'h00};
            end
            else if (i_avs_address == fpo_pkg::OFS_STATUS)
            begin
                rdata_r <= {30'h00000000, unlk_r};
            end
            else
            begin
                resp_r <= 2'h2;
            end
        end
    end

    // Operand hand-off with granularity masking of the target address
    always_comb
    begin
        o_cmd.op = op_r; // R15
        o_cmd.data = {data_r[3], data_r[2], data_r[1], data_r[0]}; // R9
        o_cmd.source = source_r;
        o_cmd.addr_used = 1'b1;
        case (op_r)
            fpo_pkg::OP_PAGE: o_cmd.address = target_r & fpo_pkg::MASK_PAGE; // R3
            fpo_pkg::OP_ROW: o_cmd.address = target_r & fpo_pkg::MASK_ROW; // R4
            fpo_pkg::OP_WORD:
            begin
                o_cmd.address = target_r & fpo_pkg::MASK_WORD; // R5
                o_cmd.data = {96'h0, data_r[0]}; // R8
            end
            fpo_pkg::OP_QUAD: o_cmd.address = target_r & fpo_pkg::MASK_QUAD; // R6
            default:
            begin
                o_cmd.address = fpo_pkg::RST_WORD; // R7
                o_cmd.addr_used = 1'b0; // R7
            end
        endcase
        if (op_r != fpo_pkg::OP_ROW)
        begin
            o_cmd.source = fpo_pkg::RST_WORD; // R10
        end
    end

    assign o_go = go_r;
    assign o_write_arm = arm_r;
    assign o_program_bank_swap = pswap_r;
    assign o_boot_bank_swap = bswap_r;

endmodule

// *** dv/fpo_regs_chk.sv ***
// Checker for the flash operand register block, bound to its top module
`timescale 1ns/1ps
module fpo_regs_chk (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_sys_rst_n,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic i_op_done,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire fpo_pkg::fpo_cmd_s o_cmd,
    input wire logic o_go,
    input wire logic o_write_arm,
    input wire logic o_program_bank_swap
);
    // One clock domain; power-on reset disables every check
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    // Key read answers zero in the answer cycle
    property p_key; i_avs_read && o_avs_waitrequest && i_avs_address == 6'h04 |=> o_avs_readdata == 32'h0; endproperty
    a_key: assert property (p_key) else $error("key read not zero");
    // Address masking per operation granularity
    property p_page; o_cmd.op == 4'h4 |-> o_cmd.address[11:0] == 12'h000 && o_cmd.addr_used; endproperty
    a_page: assert property (p_page) else $error("page address not masked");
    property p_row; o_cmd.op == 4'h3 |-> o_cmd.address[8:0] == 9'h000 && o_cmd.addr_used; endproperty
    a_row: assert property (p_row) else $error("row address not masked");
    property p_word; o_cmd.op == 4'h1 |-> o_cmd.address[1:0] == 2'h0 && o_cmd.data[127:32] == 96'h0; endproperty
    a_word: assert property (p_word) else $error("word operands wrong");
    property p_quad; o_cmd.op == 4'h2 |-> o_cmd.address[3:0] == 4'h0 && o_cmd.addr_used; endproperty
    a_quad: assert property (p_quad) else $error("quad address not masked");
    property p_other; !(o_cmd.op inside {4'h1, 4'h2, 4'h3, 4'h4}) |-> !o_cmd.addr_used && o_cmd.address == 32'h0; endproperty
    a_other: assert property (p_other) else $error("address used by other op");
    // Other resets leave operands and flags alone
    property p_keep; !i_sys_rst_n && !i_avs_write |=> $stable(o_cmd); endproperty
    a_keep: assert property (p_keep) else $error("operands lost on system reset");
    property p_flags; !i_sys_rst_n && !i_avs_write && !i_op_done |=> $stable(o_go) && $stable(o_write_arm); endproperty
    a_flags: assert property (p_flags) else $error("flags lost on system reset");
    // Swap only moves while arm is low
    property p_swap; $changed(o_program_bank_swap) |-> !$past(o_write_arm); endproperty
    a_swap: assert property (p_swap) else $error("swap changed with arm set");
    // Go: set only with arm already high, cleared only by completion
    property p_goset; $rose(o_go) |-> $past(o_write_arm); endproperty
    a_goset: assert property (p_goset) else $error("go set without arm");
    property p_gohold; o_go && !i_op_done |=> o_go; endproperty
    a_gohold: assert property (p_gohold) else $error("go cleared early");
endmodule

bind fpo_regs fpo_regs_chk u_chk (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_sys_rst_n(i_sys_rst_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_op_done(i_op_done),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_cmd(o_cmd), .o_go(o_go),
    .o_write_arm(o_write_arm), .o_program_bank_swap(o_program_bank_swap));

// *** dv/testbench.sv ***
// Self-checking bench for the flash operand register block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic sys_rst_n = 1'b1;
    logic [5:0] addr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wait_req;
    logic [1:0] resp;
    logic boot_swap = 1'b0;
    logic done = 1'b0;
    logic fail = 1'b0;
    logic low_v = 1'b0;
    fpo_pkg::fpo_cmd_s cmd;
    logic go, arm, pswap, bswap;
    int err_total = 0;
    int n_tests = 0;
    int seed = 8;
    int cyc = 0;
    int k;
    logic [31:0] q;
    logic [1:0] rsp;
    logic [31:0] regs [6];

    fpo_regs uut (.i_mclk(mclk), .i_arst_n(arst_n), .i_sys_rst_n(sys_rst_n), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .o_avs_response(resp),
        .i_boot_seq_swap(boot_swap), .i_op_done(done), .i_op_fail(fail), .i_low_voltage(low_v),
        .o_cmd(cmd), .o_go(go), .o_write_arm(arm), .o_program_bank_swap(pswap), .o_boot_bank_swap(bswap));

    // Clock and hang guard
    always #2 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            end_sim();
        end
    end

    task end_sim;
        if (err_total == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One bus transfer; request held until the rising edge that samples waitrequest low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        while (wait_req !== 1'b0)
        begin
            @(posedge mclk);
        end
        q = rdata;
        rsp = resp;
        wr <= 1'b0;
        rd <= 1'b0;
        // One idle edge so the next call never re-drives a strobe in this time step
        @(posedge mclk);
    endtask

    task unlock;
        bus(1'b1, fpo_pkg::OFS_KEY, fpo_pkg::KEY_FIRST);
        bus(1'b1, fpo_pkg::OFS_KEY, fpo_pkg::KEY_SECOND);
    endtask

    // Expected target address for an operation
    function automatic logic [31:0] exp_addr(input logic [3:0] op, input logic [31:0] a);
        case (op)
            4'h1: return a & 32'hFFFF_FFFC;
            4'h2: return a & 32'hFFFF_FFF0;
            4'h3: return a & 32'hFFFF_FE00;
            4'h4: return a & 32'hFFFF_F000;
            default: return 32'h0;
        endcase
    endfunction

    // Main sequence
    initial
    begin
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, 6'(4 + 4 * i), 32'h0);
            `CHK("reset value", 32'h0, q)
        end
        for (int i = 0; i < 24; i++)
        begin
            k = (i < 6) ? i : {$random(seed)} % 6;
            regs[k] = $random(seed);
            if (i < 6)
                regs[k] = regs[k] | 32'h0000_0FFF; // Low bits set so masking shows
            bus(1'b1, 6'(8 + 4 * k), regs[k]);
            bus(1'b1, fpo_pkg::OFS_KEY, $random(seed));
            bus(1'b0, fpo_pkg::OFS_KEY, 32'h0);
            `CHK("key read", 32'h0, q)
            bus(1'b0, 6'(8 + 4 * k), 32'h0);
            `CHK("operand", regs[k], q)
        end
        for (int op = 0; op < 8; op++)
        begin
            bus(1'b1, fpo_pkg::OFS_CONTROL, 32'(op));
            `CHK("op", 4'(op), cmd.op)
            `CHK("address", exp_addr(4'(op), regs[0]), cmd.address)
            `CHK("address used", 1'(op >= 1 && op <= 4), cmd.addr_used)
            `CHK("source", (op == 3) ? regs[5] : 32'h0, cmd.source)
            if (op == 1)
                `CHK("word data", {96'h0, regs[1]}, cmd.data)
            if (op == 2)
                `CHK("quad data", {regs[4], regs[3], regs[2], regs[1]}, cmd.data)
        end
        // Go needs arm, then the keys in order
        bus(1'b1, fpo_pkg::OFS_CONTROL, 32'h0000_4001);
        bus(1'b1, fpo_pkg::OFS_CONTROL, 32'h0000_C001);
        `CHK("go locked", 1'b0, go)
        bus(1'b1, fpo_pkg::OFS_KEY, fpo_pkg::KEY_SECOND);
        bus(1'b1, fpo_pkg::OFS_KEY, fpo_pkg::KEY_FIRST);
        bus(1'b1, fpo_pkg::OFS_CONTROL, 32'h0000_C001);
        `CHK("go wrong order", 1'b0, go)
        unlock();
        bus(1'b1, fpo_pkg::OFS_CONTROL, 32'h0000_C001);
        `CHK("go set", 1'b1, go)
        bus(1'b1, fpo_pkg::OFS_CONTROL, 32'h0000_4001);
        `CHK("go kept", 1'b1, go)
        fail <= 1'b1;
        low_v <= 1'b1;
        done <= 1'b1;
        @(posedge mclk);
        done <= 1'b0;
        fail <= 1'b0;
        low_v <= 1'b0;
        @(posedge mclk);
        `CHK("go done", 1'b0, go)
        // A system reset keeps flags and operands, reloads boot swap
        boot_swap <= 1'b1;
        sys_rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        sys_rst_n <= 1'b1;
        @(posedge mclk);
        `CHK("boot swap", 1'b1, bswap)
        bus(1'b0, fpo_pkg::OFS_CONTROL, 32'h0);
        `CHK("flags", 4'h7, q[15:12])
        bus(1'b0, fpo_pkg::OFS_TARGET, 32'h0);
        `CHK("target kept", regs[0], q)
        // Swap gated by arm, unlock and lock bits
        unlock();
        bus(1'b1, fpo_pkg::OFS_CONTROL, 32'h0000_4080);
        `CHK("swap armed", 1'b0, pswap)
        bus(1'b1, fpo_pkg::OFS_CONTROL, 32'h0000_0000);
        bus(1'b1, fpo_pkg::OFS_CONTROL2, 32'h0000_00C0);
        unlock();
        bus(1'b1, fpo_pkg::OFS_CONTROL, 32'h0000_0080);
        `CHK("swap locked", 1'b0, pswap)
        bus(1'b1, fpo_pkg::OFS_CONTROL2, 32'h0000_0000);
        bus(1'b1, fpo_pkg::OFS_CONTROL, 32'h0000_0080);
        `CHK("swap no unlock", 1'b0, pswap)
        unlock();
        bus(1'b1, fpo_pkg::OFS_CONTROL, 32'h0000_0080);
        `CHK("swap open", 1'b1, pswap)
        // Unmapped place
        bus(1'b1, 6'h3C, $random(seed));
        `CHK("unmapped write", 2'h2, rsp)
        bus(1'b0, 6'h3C, 32'h0);
        `CHK("unmapped read", 2'h2, rsp)
        end_sim();
    end
endmodule
